/* File: logic/sccd_clock_ctrl.sv */
// Sample clock divider, sampling delay, duty stabilizer and power control with serial registers
//
// How it works
// - Input clock is divided by 1, 2 or 4, chosen by the ratio register.
// - A valid system reference edge loads the divider with a programmed phase.
// - Half-period sampling delay is enabled per channel by its own register.
// - Writing the half-period delay register never resynchronises the link.
// - A three-bit control picks fine delay alone or fine plus superfine.
// - Superfine setting is unsigned; each step adds a quarter picosecond.
// - Eight-bit per-channel fine delay gives up to 192 steps.
// - Eight-bit per-channel superfine delay gives up to 128 steps.
// - Superfine delay applies only when the control holds 0x2 or 0x6.
// - Delay settings act as soon as the enabling write completes.
// - Writing the delay control with fine delay enabled resets the datapath.
// - Rewriting fine or superfine values never resynchronises the link.
// - Lower-speed variant: duty stabilizers off after reset, two enable registers.
// - Higher-speed variant: duty stabilizers on after reset.
// - Divided clock to the converter has a fifty percent duty cycle.
// - Power pin is active high and defaults to full power-down.
// - Full power-down stops the link; the pwr_b register also selects power-down.
// - Standby keeps the link up and sends zero for every sample.
// - Bit 7 of the standby output register sends K characters instead.
`timescale 1ns/1ps
`include "sccd_map.svh"

module sccd_clock_ctrl #(
    parameter bit SPEED_HIGH = 1'b1,                         // 1: higher-speed variant
    parameter int unsigned DP_RESET_CYCLES = `SCCD_DP_RESET_CYCLES // Datapath reset length
) (
    input wire logic sys_clk_in,                             // Input sample clock, 40 MHz
    input wire logic reset_in,                               // Synchronous reset, active high
    input wire logic spi_sclk_in,                            // Serial control clock
    input wire logic spi_csb_in,                             // Serial chip select, active low
    input wire logic spi_sdio_in,                            // Serial data pin, input side
    output logic spi_sdio_out,                               // Serial data pin, output side
    output logic spi_sdio_oe_n_out,                          // Low while driving serial data
    input wire logic sysref_in,                              // System reference pin
    input wire logic power_control_pin_in,                   // Power pin, active high
    input wire sccd_pkg::sccd_samples_t samples_in,          // Converter samples
    output logic div_clk_out,                                // Divided converter clock level
    output logic [1:0] ch_sample_strobe_out,                 // Per-channel sampling instant
    output sccd_pkg::sccd_delay_t delay_out,                 // Effective delay settings
    output logic duty_stabilizer_one_out,                    // Stabilizer one enable
    output logic duty_stabilizer_two_out,                    // Stabilizer two enable
    output logic datapath_reset_out,                         // Datapath reset, active high
    output logic link_enable_out,                            // Serial link running
    output logic link_resync_out,                            // Link resync request pulse
    output sccd_pkg::sccd_link_t link_out,                   // Words to the serial link
    output sccd_pkg::sccd_power_mode_t power_mode_out        // Current power mode
);

    sccd_pkg::sccd_state_t q;
    sccd_pkg::sccd_state_t n;
    logic rise;
    logic fall;
    logic wr_evt;
    logic [14:0] wr_addr;
    logic [7:0] wr_data;
    logic sref_evt;
    logic [1:0] div_lim;
    logic steady;

    // Parameter values the logic cannot serve
    if (SPEED_HIGH > 1'b1 || DP_RESET_CYCLES < 4 || DP_RESET_CYCLES > 7) begin : g_chk
        $error("sccd_clock_ctrl: DP_RESET_CYCLES must lie in 4..7");
    end

    // Constant state after reset; stabilizer default depends on the variant
    function automatic sccd_pkg::sccd_state_t rst_state();
        sccd_pkg::sccd_state_t s;
        s = '0;
        s.csb_s1 = 1'b1;
        s.csb_s2 = 1'b1;
        s.chsel = `SCCD_CHAN_SEL_RST;
        s.dcs_a = {7'h00, SPEED_HIGH};
        s.dcs_b = {7'h00, SPEED_HIGH};
        s.mode = sccd_pkg::SCCD_NORMAL;
        s.link_en = 1'b1;
        return s;
    endfunction : rst_state

    // Readback; per-channel values come from channel A while A is selected, otherwise from B
    function automatic logic [7:0] rd_reg(input sccd_pkg::sccd_state_t s, input logic [14:0] a);
        logic ch;
        logic [7:0] r;
        ch = ~s.chsel[0];
        r = 8'h00;
        unique case (a)
            `SCCD_OFF_CHAN_SEL: r = s.chsel;
            `SCCD_OFF_PWR_A: r = s.pwr_a;
            `SCCD_OFF_PWR_B: r = s.pwr_b;
            `SCCD_OFF_DIV_RATIO: r = s.ratio;
            `SCCD_OFF_SYSREF_CTL: r = s.sysref_ctl;
            `SCCD_OFF_HALF_DLY: r = s.half;
            `SCCD_OFF_DLY_CTL: r = s.dctl;
            `SCCD_OFF_SF_DLY: r = s.sf[ch];
            `SCCD_OFF_FINE_DLY: r = s.fine[ch];
            `SCCD_OFF_DCS_A: r = s.dcs_a;
            `SCCD_OFF_DCS_B: r = s.dcs_b;
            `SCCD_OFF_STBY_OUT: r = s.stby;
            default: r = 8'h00;
        endcase
        return r;
    endfunction : rd_reg

    // Divider terminal count: code 0 divides by 1, code 1 by 2, others by 4
    always_comb begin
        unique case (q.ratio[1:0])
            `SCCD_DIV1: div_lim = 2'h0;
            `SCCD_DIV2: div_lim = 2'h1;
            default: div_lim = 2'h3;
        endcase
    end

    // Edges seen only after the second synchroniser stage
    assign rise = q.sclk_s2 & ~q.sclk_s3;
    assign fall = ~q.sclk_s2 & q.sclk_s3;
    assign sref_evt = q.sref_s2 & ~q.sref_s3 & q.sysref_ctl[`SCCD_SYSREF_EN_BIT];
    assign steady = (q.mode == sccd_pkg::SCCD_NORMAL) && !sref_evt && !wr_evt;

    // Next-state logic for the whole block
    always_comb begin
        n = q;
        wr_evt = 1'b0;
        wr_addr = q.instr[14:0];
        wr_data = {q.dat[6:0], q.sdi_s2};
        // Two-flop synchronisers; the third sclk and sysref stage feeds edge detection
        n.sclk_s1 = spi_sclk_in;
        n.sclk_s2 = q.sclk_s1;
        n.sclk_s3 = q.sclk_s2;
        n.csb_s1 = spi_csb_in;
        n.csb_s2 = q.csb_s1;
        n.sdi_s1 = spi_sdio_in;
        n.sdi_s2 = q.sdi_s1;
        n.sref_s1 = sysref_in;
        n.sref_s2 = q.sref_s1;
        n.sref_s3 = q.sref_s2;
        n.pin_s1 = power_control_pin_in;
        n.pin_s2 = q.pin_s1;
        n.resync = 1'b0;

        // Serial frame: R/W bit, 15 address bits, one data byte
        if (q.csb_s2) begin
            n.bit_cnt = 5'h00;
            n.sdo_en = 1'b0;
        end else if (rise && q.bit_cnt < `SCCD_FRAME_BITS) begin
            if (q.bit_cnt < `SCCD_INSTR_BITS) begin
                n.instr = {q.instr[14:0], q.sdi_s2};
                if (q.bit_cnt == `SCCD_INSTR_BITS - 5'h01 && q.instr[14]) begin
                    n.rd = rd_reg(q, {q.instr[13:0], q.sdi_s2});
                    n.sdo_en = 1'b1;
                end
            end else begin
                n.dat = wr_data;
                wr_evt = (q.bit_cnt == `SCCD_FRAME_BITS - 5'h01) && !q.instr[15];
            end
            n.bit_cnt = q.bit_cnt + 5'h01;
        end else if (fall && q.sdo_en && q.bit_cnt >= `SCCD_INSTR_BITS
                     && q.bit_cnt < `SCCD_FRAME_BITS) begin
            n.sdo = q.rd[7];
            n.rd = {q.rd[6:0], 1'b0};
        end

        // Datapath reset countdown
        if (q.dp_cnt != 3'h0) begin
            n.dp_cnt = q.dp_cnt - 3'h1;
        end

        // Register writes land at the end of the data byte and act at once
        if (wr_evt) begin
            unique case (wr_addr)
                `SCCD_OFF_CHAN_SEL: n.chsel = wr_data;
                `SCCD_OFF_PWR_A: n.pwr_a = wr_data;
                `SCCD_OFF_PWR_B: n.pwr_b = wr_data;
                `SCCD_OFF_DIV_RATIO: begin
                    n.ratio = wr_data;
                    n.resync = 1'b1;
                end
                `SCCD_OFF_SYSREF_CTL: n.sysref_ctl = wr_data;
                `SCCD_OFF_HALF_DLY: n.half = wr_data;
                `SCCD_OFF_DLY_CTL: begin
                    n.dctl = wr_data;
                    if (wr_data[2:0] != 3'h0) begin
                        n.dp_cnt = 3'(DP_RESET_CYCLES);
                    end
                end
                `SCCD_OFF_SF_DLY: begin
                    for (int i = 0; i < 2; i++) begin
                        if (q.chsel[i]) begin
                            // Unsigned, clamped to the full range
                            n.sf[i] = (wr_data > `SCCD_SF_MAX) ? `SCCD_SF_MAX : wr_data;
                        end
                    end
                end
                `SCCD_OFF_FINE_DLY: begin
                    for (int i = 0; i < 2; i++) begin
                        if (q.chsel[i]) begin
                            // Clamped to the full range
                            n.fine[i] = (wr_data > `SCCD_FINE_MAX) ? `SCCD_FINE_MAX : wr_data;
                        end
                    end
                end
                `SCCD_OFF_DCS_A: n.dcs_a = wr_data;
                `SCCD_OFF_DCS_B: n.dcs_b = wr_data;
                `SCCD_OFF_STBY_OUT: n.stby = wr_data;
                default: n.chsel = q.chsel;
            endcase
        end

        // Power mode: pin wins over the registers, power-down over standby
        if (q.pin_s2) begin
            n.mode = q.pwr_a[`SCCD_PIN_STBY_BIT] ? sccd_pkg::SCCD_STANDBY
                                                 : sccd_pkg::SCCD_POWER_DOWN;
        end else if (q.pwr_b[1]) begin
            n.mode = sccd_pkg::SCCD_POWER_DOWN;
        end else if (q.pwr_b[0]) begin
            n.mode = sccd_pkg::SCCD_STANDBY;
        end else begin
            n.mode = sccd_pkg::SCCD_NORMAL;
        end
        // Coming back from power-down the link must realign
        if (q.mode == sccd_pkg::SCCD_POWER_DOWN && n.mode != sccd_pkg::SCCD_POWER_DOWN) begin
            n.resync = 1'b1;
        end

        // Divider: alignment load, otherwise count only while sampling
        if (sref_evt) begin
            n.cnt = q.sysref_ctl[`SCCD_SYSREF_PH_MSB:`SCCD_SYSREF_PH_LSB] & div_lim;
        end else if (q.mode == sccd_pkg::SCCD_NORMAL) begin
            n.cnt = (q.cnt >= div_lim) ? 2'h0 : q.cnt + 2'h1;
        end else begin
            n.cnt = 2'h0; // Settings stay in registers for the restart
        end
        // Clock level high for the first half of each count, so duty stays even
        if (q.mode != sccd_pkg::SCCD_NORMAL) begin
            n.div_clk = 1'b0;
        end else if (div_lim == 2'h0) begin
            n.div_clk = ~q.div_clk;
        end else begin
            n.div_clk = (q.cnt <= (div_lim >> 1));
        end
        n.strobe = (q.mode == sccd_pkg::SCCD_NORMAL) && (q.cnt == 2'h0);
        n.strobe_d1 = q.strobe;

        // Link words: samples, zeros or K characters; none in power-down
        n.link_en = (q.mode != sccd_pkg::SCCD_POWER_DOWN);
        n.link.is_k = (q.mode == sccd_pkg::SCCD_STANDBY) && q.stby[`SCCD_STBY_K_BIT];
        for (int i = 0; i < 2; i++) begin
            unique case (q.mode)
                sccd_pkg::SCCD_NORMAL: n.link.word[i] = {samples_in.word[i], 2'b00};
                sccd_pkg::SCCD_STANDBY: n.link.word[i] = q.stby[`SCCD_STBY_K_BIT]
                    ? {`SCCD_K_CHAR, `SCCD_K_CHAR} : 16'h0000;
                default: n.link.word[i] = 16'h0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            q <= rst_state();
        end else begin
            q <= n;
        end
    end

    // Per-channel sampling instant and delay settings
    for (genvar g = 0; g < 2; g++) begin : g_ch
        // Half-period delay shifts the instant by one input clock step
        assign ch_sample_strobe_out[g] = q.half[g] ? q.strobe_d1 : q.strobe;
        assign delay_out.fine[g] = q.fine[g];
        // Superfine only counts in the two combined modes
        assign delay_out.superfine[g] = (q.dctl[2:0] == `SCCD_SF_MODE_A
            || q.dctl[2:0] == `SCCD_SF_MODE_B) ? q.sf[g] : 8'h00;
        assign delay_out.half_en[g] = q.half[g];
    end
    assign delay_out.mode = q.dctl[2:0];

    // Outputs straight from the state
    assign spi_sdio_out = q.sdo;
    assign spi_sdio_oe_n_out = ~q.sdo_en;
    assign div_clk_out = q.div_clk;
    assign duty_stabilizer_one_out = q.dcs_a[`SCCD_DCS_EN_BIT];
    assign duty_stabilizer_two_out = q.dcs_b[`SCCD_DCS_EN_BIT];
    assign datapath_reset_out = (q.dp_cnt != 3'h0);
    assign link_enable_out = q.link_en;
    assign link_resync_out = q.resync;
    assign link_out = q.link;
    assign power_mode_out = q.mode;

    // Divide-by-four strobe spacing when nothing disturbs the divider
    sequence quiet_run_s;
        steady [*4];
    endsequence
    property div4_period_p;
        @(posedge sys_clk_in) disable iff (reset_in)
        (q.strobe && div_lim == 2'h3 && $past(steady)) ##0 quiet_run_s
        |=> q.strobe && !$past(q.strobe) && !$past(q.strobe, 2);
    endproperty
    div4_period_a: assert property (div4_period_p)
        else $error("divide-by-four strobe spacing wrong");

    sysref_load_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        sref_evt |=> q.cnt == ($past(q.sysref_ctl[5:4]) & $past(div_lim)))
        else $error("divider not loaded on system reference");

    half_delay_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (q.half[1] && $stable(q.half[1])) |-> ch_sample_strobe_out[1] == $past(q.strobe))
        else $error("half-period delay not one step late");

    // A delay value write followed by two quiet link cycles
    sequence dly_write_s;
        wr_evt && (wr_addr == `SCCD_OFF_HALF_DLY || wr_addr == `SCCD_OFF_SF_DLY
            || wr_addr == `SCCD_OFF_FINE_DLY) && q.mode == sccd_pkg::SCCD_NORMAL
            && !q.pin_s2 && !q.pwr_b[1];
    endsequence
    link_quiet_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        dly_write_s |=> !link_resync_out [*2])
        else $error("delay write disturbed the link");

    sf_gate_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (q.dctl[2:0] != `SCCD_SF_MODE_A && q.dctl[2:0] != `SCCD_SF_MODE_B)
        |-> delay_out.superfine == 16'h0000)
        else $error("superfine active outside its modes");

    fine_now_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (wr_evt && wr_addr == `SCCD_OFF_FINE_DLY && q.chsel[0])
        |=> delay_out.fine[0] == (($past(wr_data) > 8'hC0) ? 8'hC0 : $past(wr_data)))
        else $error("fine delay not applied at once");

    dp_reset_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (wr_evt && wr_addr == `SCCD_OFF_DLY_CTL && wr_data[2:0] != 3'h0)
        |=> datapath_reset_out [*4])
        else $error("datapath reset missing after fine delay enable");

    dcs_default_a: assert property (@(posedge sys_clk_in)
        $fell(reset_in) |-> duty_stabilizer_one_out == SPEED_HIGH
            && duty_stabilizer_two_out == SPEED_HIGH)
        else $error("stabilizer reset state wrong");

    pin_down_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (q.pin_s2 && !q.pwr_a[0]) |=> ##1 !link_enable_out)
        else $error("power pin did not stop the link");

    standby_fill_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (q.mode == sccd_pkg::SCCD_STANDBY) |=> link_enable_out
            && link_out.is_k == $past(q.stby[7])
            && link_out.word[0] == ($past(q.stby[7]) ? 16'hBCBC : 16'h0000))
        else $error("standby link content wrong");

    // Divide-by-two level alternates while the divider runs undisturbed
    div2_duty_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (div_lim == 2'h1 && $past(div_lim) == 2'h1 && steady && $past(steady))
        |=> div_clk_out != $past(div_clk_out))
        else $error("divide-by-two clock not even");

    // Register power-down alone must also stop the link
    reg_down_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (q.pwr_b[1] && !q.pin_s2) |=> ##1 !link_enable_out)
        else $error("register power-down kept the link");

    // Parked divider: no strobe outside normal mode, settings kept for the restart
    divider_park_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (q.mode != sccd_pkg::SCCD_NORMAL && $past(q.mode) != sccd_pkg::SCCD_NORMAL && !wr_evt)
        |=> ch_sample_strobe_out == 2'b00 && $stable(q.ratio) && $stable(q.dctl))
        else $error("divider not parked or settings lost");

    dcs_write_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (wr_evt && wr_addr == `SCCD_OFF_DCS_B) |=> duty_stabilizer_two_out == $past(wr_data[0]))
        else $error("stabilizer enable not applied");

endmodule : sccd_clock_ctrl

/* File: logic/sccd_map.svh */
// Register offsets, field positions, reset values and counts of the clock control block
`ifndef SCCD_MAP_SVH
`define SCCD_MAP_SVH

// Register offsets (15-bit serial control address)
`define SCCD_OFF_CHAN_SEL 15'h0008
`define SCCD_OFF_PWR_A 15'h003F
`define SCCD_OFF_PWR_B 15'h0040
`define SCCD_OFF_DIV_RATIO 15'h0108
`define SCCD_OFF_SYSREF_CTL 15'h0109
`define SCCD_OFF_HALF_DLY 15'h010C
`define SCCD_OFF_DLY_CTL 15'h0110
`define SCCD_OFF_SF_DLY 15'h0111
`define SCCD_OFF_FINE_DLY 15'h0112
`define SCCD_OFF_DCS_A 15'h011C
`define SCCD_OFF_DCS_B 15'h011E
`define SCCD_OFF_STBY_OUT 15'h0571

// Field positions
`define SCCD_STBY_K_BIT 7
`define SCCD_PIN_STBY_BIT 0
`define SCCD_SYSREF_EN_BIT 0
`define SCCD_SYSREF_PH_MSB 5
`define SCCD_SYSREF_PH_LSB 4
`define SCCD_DCS_EN_BIT 0

// Reset values
`define SCCD_CHAN_SEL_RST 8'h03
`define SCCD_REG_RST 8'h00

// Divider ratio codes
`define SCCD_DIV1 2'h0
`define SCCD_DIV2 2'h1

// Delay limits and superfine enabling modes
`define SCCD_FINE_MAX 8'hC0
`define SCCD_SF_MAX 8'h80
`define SCCD_SF_MODE_A 3'h2
`define SCCD_SF_MODE_B 3'h6
`define SCCD_SF_STEP_FS 250

// Link filler character and serial frame lengths
`define SCCD_K_CHAR 8'hBC
`define SCCD_INSTR_BITS 5'h10
`define SCCD_FRAME_BITS 5'h18

// Datapath reset pulse length in clock cycles
`define SCCD_DP_RESET_CYCLES 4

`endif

/* File: logic/sccd_pkg.sv */
// Types shared by the sample clock control block
package sccd_pkg;

    typedef enum logic [1:0] {
        SCCD_NORMAL,
        SCCD_STANDBY,
        SCCD_POWER_DOWN
    } sccd_power_mode_t;

    // Converter samples, one word per channel
    typedef struct packed {
        logic [1:0][13:0] word;
    } sccd_samples_t;

    // Words handed to the serial link
    typedef struct packed {
        logic [1:0][15:0] word;
        logic is_k;
    } sccd_link_t;

    // Sampling edge delay settings per channel
    typedef struct packed {
        logic [2:0] mode;
        logic [1:0][7:0] fine;
        logic [1:0][7:0] superfine;
        logic [1:0] half_en;
    } sccd_delay_t;

    // Whole state of the block
    typedef struct packed {
        logic sclk_s1, sclk_s2, sclk_s3;
        logic csb_s1, csb_s2;
        logic sdi_s1, sdi_s2;
        logic sref_s1, sref_s2, sref_s3;
        logic pin_s1, pin_s2;
        logic [4:0] bit_cnt;
        logic [15:0] instr;
        logic [7:0] dat;
        logic [7:0] rd;
        logic sdo;
        logic sdo_en;
        logic [7:0] chsel, pwr_a, pwr_b, ratio, sysref_ctl, half, dctl;
        logic [1:0][7:0] sf;
        logic [1:0][7:0] fine;
        logic [7:0] dcs_a, dcs_b, stby;
        logic [1:0] cnt;
        logic div_clk;
        logic strobe;
        logic strobe_d1;
        logic [2:0] dp_cnt;
        logic resync;
        sccd_power_mode_t mode;
        sccd_link_t link;
        logic link_en;
    } sccd_state_t;

endpackage : sccd_pkg

/* File: tb/sccd_spi_host.sv */
// Serial control host model for the register port of the clock control block
`timescale 1ns/1ps

module sccd_spi_host (
    input wire logic clk_in,      // System clock, paces the serial clock
    input wire logic sdo_in,      // Read data driven by the device
    input wire logic sdo_oe_n_in, // Device drives the line while low
    output logic sclk_out,        // Serial clock, idles low
    output logic csb_out,         // Chip select, active low
    output logic sdio_out         // Resolved level of the data line
);
    logic host_bit;

    // Device owns the line during read data, host otherwise
    assign sdio_out = sdo_oe_n_in ? host_bit : sdo_in;

    // Idle frame levels at time zero
    initial begin
        sclk_out = 1'b0;
        csb_out = 1'b1;
        host_bit = 1'b0;
    end

    // One frame; halves of 5 clocks keep clear of the 4-clock minimum
    task automatic xfer(input logic rd, input logic [14:0] adr, input logic [7:0] wd,
                        output logic [7:0] rdat);
        logic [23:0] f;
        f = {rd, adr, wd};
        rdat = 8'h00;
        @(posedge clk_in) csb_out <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge clk_in) host_bit <= f[i];
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b1;
            if (i < 8) rdat[i] = sdio_out;
            repeat (5) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        // Commit lands before chip select is raised
        repeat (6) @(posedge clk_in);
        csb_out <= 1'b1;
        host_bit <= ~host_bit;
        repeat (5) @(posedge clk_in);
    endtask : xfer
endmodule : sccd_spi_host

/* File: tb/sample_clock_divider_delay_ctrl_bench.sv */
// Self-checking bench for the sample clock control block
`timescale 1ns/1ps
`include "sccd_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module sample_clock_divider_delay_ctrl_bench;
    localparam int DPR = `SCCD_DP_RESET_CYCLES;
    logic sys_clk_in, reset_in, sclk, csb, sdio, sdo, oe_n, pin, sref;
    logic div_clk, duty_stabilizer_one, duty_stabilizer_two, dpr, len, rsy;
    logic [1:0] stb;
    sccd_pkg::sccd_samples_t samp;
    sccd_pkg::sccd_delay_t dly;
    sccd_pkg::sccd_link_t lnk;
    sccd_pkg::sccd_power_mode_t pm;
    int miscompares = 0, num_checks = 0, n_rsy = 0, n_dpr = 0;
    logic [14:0] offs [8] = '{15'h003F, 15'h0040, 15'h0108, 15'h010C, 15'h0110, 15'h0111,
                              15'h0112, 15'h0571};

    sccd_clock_ctrl i_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .spi_sclk_in(sclk),
        .spi_csb_in(csb), .spi_sdio_in(sdio), .spi_sdio_out(sdo), .spi_sdio_oe_n_out(oe_n),
        .sysref_in(sref), .power_control_pin_in(pin), .samples_in(samp), .div_clk_out(div_clk),
        .ch_sample_strobe_out(stb), .delay_out(dly), .duty_stabilizer_one_out(duty_stabilizer_one),
        .duty_stabilizer_two_out(duty_stabilizer_two), .datapath_reset_out(dpr), .link_enable_out(len),
        .link_resync_out(rsy), .link_out(lnk), .power_mode_out(pm));
    sccd_spi_host i_host (.clk_in(sys_clk_in), .sdo_in(sdo), .sdo_oe_n_in(oe_n),
        .sclk_out(sclk), .csb_out(csb), .sdio_out(sdio));

    // 40 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    // Pulse tallies, so short pulses are never missed between checks
    always @(posedge sys_clk_in) begin
        n_rsy += int'(rsy === 1'b1);
        n_dpr += int'(dpr === 1'b1);
    end

    function automatic int ratio(input logic [1:0] c);
        return (c == 2'h0) ? 1 : (c == 2'h1) ? 2 : 4;
    endfunction : ratio
    function automatic logic [7:0] exp_fine(input logic [7:0] v);
        return (v > 8'hC0) ? 8'hC0 : v;
    endfunction : exp_fine
    function automatic logic [7:0] exp_sf(input logic [2:0] m, input logic [7:0] v);
        return (m == 3'h2 || m == 3'h6) ? ((v > 8'h80) ? 8'h80 : v) : 8'h00;
    endfunction : exp_sf

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] x;
        i_host.xfer(1'b0, a, d, x);
    endtask : wr
    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] x;
        i_host.xfer(1'b1, a, 8'h00, x);
        `CHK(x, e)
    endtask : rd_chk
    task automatic set_pin(input logic v);
        @(posedge sys_clk_in) pin <= v;
        repeat (8) @(posedge sys_clk_in);
    endtask : set_pin
    // Window of 40 is a multiple of every ratio, so counts are exact
    task automatic count_strobes(input logic [1:0] c);
        int ns, nh;
        ns = 0;
        nh = 0;
        repeat (40) begin
            @(posedge sys_clk_in);
            ns += int'(stb[0] === 1'b1);
            nh += int'(div_clk === 1'b1);
        end
        `CHK(ns, 40 / ratio(c))
        if (c != 2'h0) `CHK(nh, 20)
    endtask : count_strobes

    task automatic stop_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    // Watchdog well beyond the expected run of about 12600 cycles
    initial begin
        repeat (60000) @(posedge sys_clk_in);
        miscompares++;
        stop_test();
    end

    initial begin
        logic [7:0] f, s;
        int r0, d0, n_al;
        reset_in = 1'b1;
        pin = 1'b0;
        sref = 1'b0;
        samp = '0;
        void'($urandom(32'hcd3783c0));
        repeat (3) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        samp <= 28'($urandom);
        @(posedge sys_clk_in);
        `CHK(duty_stabilizer_two, 1'b1)
        `CHK(duty_stabilizer_one, 1'b1)
        `CHK(pm, sccd_pkg::SCCD_NORMAL)
        foreach (offs[i]) rd_chk(offs[i], `SCCD_REG_RST);
        rd_chk(`SCCD_OFF_DCS_A, 8'h01);
        rd_chk(15'h0ABC, 8'h00);
        wr(`SCCD_OFF_DCS_B, 8'h00);
        `CHK(duty_stabilizer_two, 1'b0)
        wr(`SCCD_OFF_DCS_B, 8'h01);
        `CHK(duty_stabilizer_two, 1'b1)
        `CHK(lnk.word[0], {samp.word[0], 2'b00})
        $display("reset and stabilizer test done");
        // Ratio programmed before the divided clock is relied on
        for (int c = 0; c < 4; c++) begin
            wr(`SCCD_OFF_DIV_RATIO, 8'(c));
            count_strobes(2'(c));
        end
        $display("divider test done");
        r0 = n_rsy;
        wr(`SCCD_OFF_HALF_DLY, 8'h02);
        `CHK(n_rsy, r0)
        `CHK(dly.half_en, 2'b10)
        for (int i = 0; i < 8 && stb[0] !== 1'b1; i++) @(posedge sys_clk_in);
        `CHK(stb[1], 1'b0)
        @(posedge sys_clk_in);
        `CHK(stb[1], 1'b1)
        $display("half period test done");
        // System reference loads phase 0, then 2, into the divide-by-four count
        for (int ph = 0; ph < 4; ph += 2) begin
            wr(`SCCD_OFF_SYSREF_CTL, 8'(ph * 16 + 1));
            @(posedge sys_clk_in) sref <= 1'b1;
            repeat (4) @(posedge sys_clk_in);
            for (n_al = 1; n_al < 8; n_al++) begin
                @(posedge sys_clk_in);
                if (stb[0] === 1'b1) break;
            end
            `CHK(n_al, 1 + (4 - ph) % 4)
            sref <= 1'b0;
        end
        $display("alignment test done");
        // Every control code, with clamp corners among random values
        for (int k = 0; k < 8; k++) begin
            f = (k == 0) ? 8'hC1 : 8'($urandom);
            s = (k == 2) ? 8'h81 : 8'($urandom);
            r0 = n_rsy;
            wr(`SCCD_OFF_FINE_DLY, f);
            wr(`SCCD_OFF_SF_DLY, s);
            `CHK(n_rsy, r0)
            d0 = n_dpr;
            wr(`SCCD_OFF_DLY_CTL, 8'(k));
            `CHK(n_dpr - d0, (k != 0) ? DPR : 0)
            `CHK(dly.mode, 3'(k))
            `CHK(dly.fine[1], exp_fine(f))
            `CHK(dly.superfine[0], exp_sf(3'(k), s))
        end
        $display("delay test done");
        wr(`SCCD_OFF_PWR_A, 8'h01);
        set_pin(1'b1);
        `CHK(pm, sccd_pkg::SCCD_STANDBY)
        `CHK(len, 1'b1)
        `CHK(lnk.word[1], 16'h0000)
        wr(`SCCD_OFF_STBY_OUT, 8'h80);
        `CHK(lnk.word[0], {2{`SCCD_K_CHAR}})
        `CHK(lnk.is_k, 1'b1)
        set_pin(1'b0);
        wr(`SCCD_OFF_PWR_A, 8'h00);
        set_pin(1'b1);
        `CHK(pm, sccd_pkg::SCCD_POWER_DOWN)
        `CHK(len, 1'b0)
        set_pin(1'b0);
        wr(`SCCD_OFF_PWR_B, 8'h02);
        `CHK(pm, sccd_pkg::SCCD_POWER_DOWN)
        wr(`SCCD_OFF_PWR_B, 8'h01);
        `CHK(pm, sccd_pkg::SCCD_STANDBY)
        wr(`SCCD_OFF_PWR_B, 8'h00);
        repeat (4) @(posedge sys_clk_in);
        `CHK(dly.mode, 3'h7)
        count_strobes(2'h3);
        $display("power test done");
        stop_test();
    end
endmodule : sample_clock_divider_delay_ctrl_bench
